// *** hdl/rxls_bip_chk.sv ***
// per-lane parity signature compare
`timescale 1ns/1ps
`include "rxls_defs.svh"
module rxls_bip_chk (
    input  wire logic             clk_sys,  // system clock
    input  wire logic             rst_n,    // sync reset
    input  wire logic [19:0]      bipValid, // signature byte arrived
    input  wire logic [19:0][7:0] bipRx,    // received signature
    input  wire logic [19:0][7:0] bipCalc,  // computed signature
    output logic [19:0]           bipErr    // one-cycle error pulses
);
    rxls_pkg::rxls_bip_t bip_reg;
    rxls_pkg::rxls_bip_t bip_next;

    always_comb begin
        bip_next = '0;
        for (int i = 0; i < `RXLS_LANES; i++) begin
            bip_next.err[i] = bipValid[i] && (bipRx[i] != bipCalc[i]); // RULE12 RULE13
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bip_reg <= '0;
        end else begin
            bip_reg <= bip_next;
        end
    end

    assign bipErr = bip_reg.err;
endmodule

// *** hdl/rxls_defs.svh ***
// constants of the receive lane and frame status block
// Notes on behaviour
// RULE1 - Each physical lane has a 5-bit level output naming its PCS lane.
// RULE2 - A lane's PCS lane number is valid only while its sync bit is one.
// RULE3 - A 20-bit level vector shows which PCS lanes are demultiplexed.
// RULE4 - A 4-bit output counts packets with a bad, not stomped, FCS.
// RULE5 - An FCS equal to the inverse of the computed FCS is stomped.
// RULE6 - A 4-bit output counts packets carrying a stomped FCS.
// RULE7 - Bad and stomped counts last one cycle and may run back to back.
// RULE8 - A packet longer than the 15-bit maximum length is truncated.
// RULE9 - The truncation pulse lasts one cycle per event, back to back ok.
// RULE10 - Internal local fault is high while test, misalign or high BER.
// RULE11 - Received local fault is high while the fault machine says so.
// RULE12 - Each PCS lane has a one-bit BIP8 mismatch error output.
// RULE13 - Each BIP8 error is a one-cycle pulse, back to back allowed.
// RULE14 - Event counts carry this cycle's events and are zero otherwise.
`ifndef RXLS_DEFS_SVH
`define RXLS_DEFS_SVH
`define RXLS_LANES        20
`define RXLS_FCS_PER_CYC  4
`define RXLS_OFS_MAXLEN   8'h00
`define RXLS_OFS_STATUS   8'h04
`define RXLS_OFS_CLEAR    8'h08
`define RXLS_OFS_ENABLE   8'h0C
`define RXLS_OFS_SYNCED   8'h10
`define RXLS_OFS_DEMUXED  8'h14
`define RXLS_MAXLEN_RST   15'h2580
`define RXLS_EV_BAD       0
`define RXLS_EV_STOMP     1
`define RXLS_EV_TRUNC     2
`define RXLS_EV_BIP       3
`define RXLS_EV_INTLF     4
`define RXLS_EV_RXLF      5
`define RXLS_EV_NUM       6
`define RXLS_LF_SEQ_LAST  2'h3
`define RXLS_LF_COL_LAST  7'h7F
`define RXLS_RESP_OKAY    2'h0
`define RXLS_RESP_SLVERR  2'h2
`endif

// *** hdl/rxls_lf_fsm.sv ***
// received local fault state machine
`timescale 1ns/1ps
`include "rxls_defs.svh"
module rxls_lf_fsm (
    input  wire logic clk_sys,    // system clock
    input  wire logic rst_n,      // sync reset
    input  wire logic colValid,   // a column was received
    input  wire logic colIsLf,    // that column is a local fault sequence
    output logic      faultOut    // received local fault level
);
    rxls_pkg::rxls_lf_t lf_reg;
    rxls_pkg::rxls_lf_t lf_next;

    always_comb begin
        lf_next = lf_reg;
        case (lf_reg.st)
            rxls_pkg::LF_IDLE: begin
                if (colValid && colIsLf) begin
                    lf_next.st = rxls_pkg::LF_COUNT;
                    lf_next.seqCnt = 2'h1;
                    lf_next.colCnt = 7'h00;
                end
            end
            rxls_pkg::LF_COUNT: begin
                if (colValid && colIsLf) begin
                    lf_next.colCnt = 7'h00;
                    if (lf_reg.seqCnt == `RXLS_LF_SEQ_LAST) begin
                        lf_next.st = rxls_pkg::LF_FAULT;
                        lf_next.fault = 1'b1; // RULE11
                    end else begin
                        lf_next.seqCnt = lf_reg.seqCnt + 2'h1;
                    end
                end else if (colValid) begin
                    lf_next.colCnt = lf_reg.colCnt + 7'h01;
                    if (lf_reg.colCnt == `RXLS_LF_COL_LAST) begin
                        lf_next.st = rxls_pkg::LF_IDLE;
                    end
                end
            end
            rxls_pkg::LF_FAULT: begin
                // fault holds until a full window passes without one
                if (colValid && colIsLf) begin
                    lf_next.colCnt = 7'h00;
                end else if (colValid) begin
                    lf_next.colCnt = lf_reg.colCnt + 7'h01;
                    if (lf_reg.colCnt == `RXLS_LF_COL_LAST) begin
                        lf_next.st = rxls_pkg::LF_IDLE;
                        lf_next.fault = 1'b0; // RULE11
                    end
                end
            end
            default: begin
                lf_next.st = rxls_pkg::LF_IDLE;
                lf_next.fault = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lf_reg <= '{st: rxls_pkg::LF_IDLE, default: '0};
        end else begin
            lf_reg <= lf_next;
        end
    end

    assign faultOut = lf_reg.fault;
endmodule

// *** hdl/rxls_pkg.sv ***
// types of the receive lane and frame status block
package rxls_pkg;
    typedef enum logic [2:0] {
        LF_IDLE  = 3'h1,
        LF_COUNT = 3'h2,
        LF_FAULT = 3'h4
    } rxls_lf_state_t;

    typedef struct packed {
        rxls_lf_state_t st;
        logic [1:0]     seqCnt;
        logic [6:0]     colCnt;
        logic           fault;
    } rxls_lf_t;

    typedef struct packed {
        logic [19:0] err;
    } rxls_bip_t;

    typedef struct packed {
        logic [19:0][4:0] pcslNum;
        logic [19:0]      synced;
        logic [19:0]      demuxed;
        logic [3:0]       badFcs;
        logic [3:0]       stomped;
        logic             trunc;
        logic             intLf;
        logic [15:0]      pktLen;
        logic             cutting;
        logic [14:0]      maxLen;
        logic [5:0]       irqSts;
        logic [5:0]       irqEn;
        logic             irq;
        logic             awRdy;
        logic             wRdy;
        logic [7:0]       awAddr;
        logic [31:0]      wData;
        logic [3:0]       wStrb;
        logic             bValid;
        logic [1:0]       bResp;
        logic             arRdy;
        logic             rValid;
        logic [31:0]      rData;
        logic [1:0]       rResp;
    } rxls_state_t;
endpackage

// *** hdl/rxls_top.sv ***
// receive lane and frame status with register access
`timescale 1ns/1ps
`include "rxls_defs.svh"
module rxls_top #(
    parameter int NUM_LANES = 20,
    parameter int FCS_PER_CYC = 4
) (
    input  wire logic              clk_sys,         // system clock
    input  wire logic              rst_n,           // sync reset
    input  wire logic [19:0]       laneSynced,      // per-lane sync
    input  wire logic [19:0][4:0]  lanePcslIn,      // found lane numbers
    input  wire logic [19:0]       laneDemuxed,     // marker locks
    input  wire logic [3:0]        fcsValid,        // packet ends
    input  wire logic [3:0][31:0]  fcsRx,           // received FCS
    input  wire logic [3:0][31:0]  fcsCalc,         // computed FCS
    input  wire logic              rxEna,           // data word valid
    input  wire logic              rxSop,           // first word
    input  wire logic              rxEop,           // last word
    input  wire logic [6:0]        rxBytes,         // bytes in word
    input  wire logic              txTestPattern,   // test generation on
    input  wire logic              rxAlignBad,      // alignment bad
    input  wire logic              rxHiBer,         // high error rate
    input  wire logic              colValid,        // column received
    input  wire logic              colIsLf,         // column is LF seq
    input  wire logic [19:0]       bipValid,        // signature arrived
    input  wire logic [19:0][7:0]  bipRx,           // received signature
    input  wire logic [19:0][7:0]  bipCalc,         // computed signature
    output logic [19:0][4:0]       statPcslNum,     // lane numbers
    output logic [19:0]            statSynced,      // sync qualifier
    output logic [19:0]            statDemuxed,     // demux flags
    output logic [3:0]             statBadFcs,      // bad FCS count
    output logic [3:0]             statStompedFcs,  // stomped count
    output logic                   statTruncated,   // truncation pulse
    output logic                   statIntLf,       // internal fault
    output logic                   statRxLf,        // received fault
    output logic [19:0]            statBipErr,      // parity pulses
    output logic                   irq,             // interrupt level
    input  wire logic [7:0]        s_axi_awaddr,    // write address
    input  wire logic              s_axi_awvalid,   // write addr valid
    output logic                   s_axi_awready,   // write addr ready
    input  wire logic [31:0]       s_axi_wdata,     // write data
    input  wire logic [3:0]        s_axi_wstrb,     // byte enables
    input  wire logic              s_axi_wvalid,    // write data valid
    output logic                   s_axi_wready,    // write data ready
    output logic [1:0]             s_axi_bresp,     // write response
    output logic                   s_axi_bvalid,    // response valid
    input  wire logic              s_axi_bready,    // response ready
    input  wire logic [7:0]        s_axi_araddr,    // read address
    input  wire logic              s_axi_arvalid,   // read addr valid
    output logic                   s_axi_arready,   // read addr ready
    output logic [31:0]            s_axi_rdata,     // read data
    output logic [1:0]             s_axi_rresp,     // read response
    output logic                   s_axi_rvalid,    // read valid
    input  wire logic              s_axi_rready     // read ready
);
    if (NUM_LANES != `RXLS_LANES || FCS_PER_CYC != `RXLS_FCS_PER_CYC) begin
        $error("rxls_top: lane or FCS count not supported");
    end

    rxls_pkg::rxls_state_t s_reg;
    rxls_pkg::rxls_state_t s_next;
    logic                  rxLfLvl;
    logic [19:0]           bipErrLvl;

    function automatic logic [3:0] count4(input logic [3:0] v);
        count4 = {3'h0, v[0]} + {3'h0, v[1]} + {3'h0, v[2]} + {3'h0, v[3]};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  strb);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = strb[b] ? dat[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    rxls_lf_fsm u_lf (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .colValid (colValid),
        .colIsLf  (colIsLf),
        .faultOut (rxLfLvl)
    );

    rxls_bip_chk u_bip (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .bipValid (bipValid),
        .bipRx    (bipRx),
        .bipCalc  (bipCalc),
        .bipErr   (bipErrLvl)
    );

    always_comb begin
        logic [3:0]  badV;
        logic [3:0]  stompV;
        logic [15:0] lenAfter;
        logic [5:0]  ev;
        logic [5:0]  clr;
        logic [31:0] mrg;
        logic        doWr;
        logic [31:0] upd;

        badV = '0;
        stompV = '0;
        lenAfter = '0;
        ev = '0;
        clr = '0;
        mrg = '0;
        doWr = 1'b0;
        upd = '0;
        s_next = s_reg;

        for (int l = 0; l < `RXLS_LANES; l++) begin
            // zero while unsynced so stale numbers never leak
            s_next.pcslNum[l] = laneSynced[l] ? lanePcslIn[l] : 5'h00; // RULE1 RULE2
        end
        s_next.synced = laneSynced; // RULE2
        s_next.demuxed = laneDemuxed; // RULE3

        for (int f = 0; f < `RXLS_FCS_PER_CYC; f++) begin
            stompV[f] = fcsValid[f] && (fcsRx[f] == ~fcsCalc[f]); // RULE5
            badV[f] = fcsValid[f] && (fcsRx[f] != fcsCalc[f])
                      && !stompV[f]; // RULE4
        end
        s_next.badFcs = count4(badV); // RULE4 RULE7 RULE14
        s_next.stomped = count4(stompV); // RULE6 RULE7 RULE14

        // length stops growing once cut, so 16 bits never wrap
        s_next.trunc = 1'b0; // RULE9
        if (rxEna) begin
            lenAfter = (rxSop ? 16'h0000 : s_reg.pktLen) + {9'h000, rxBytes};
            if (rxSop || !s_reg.cutting) begin
                s_next.pktLen = lenAfter;
                if (lenAfter > {1'b0, s_reg.maxLen}) begin
                    s_next.trunc = 1'b1; // RULE8 RULE9
                    s_next.cutting = 1'b1; // RULE8
                end else begin
                    s_next.cutting = 1'b0;
                end
            end
            if (rxEop) begin
                s_next.pktLen = 16'h0000;
                s_next.cutting = 1'b0;
            end
        end

        // a plain level: it falls as soon as every cause is gone
        s_next.intLf = txTestPattern || rxAlignBad || rxHiBer; // RULE10

        // every event sets its sticky status bit
        ev[`RXLS_EV_BAD] = |badV;
        ev[`RXLS_EV_STOMP] = |stompV;
        ev[`RXLS_EV_TRUNC] = s_next.trunc;
        ev[`RXLS_EV_BIP] = |bipErrLvl;
        ev[`RXLS_EV_INTLF] = s_reg.intLf;
        ev[`RXLS_EV_RXLF] = rxLfLvl;

        // write channel: address and data taken in either order
        if (s_axi_awvalid && s_reg.awRdy) begin
            s_next.awAddr = s_axi_awaddr;
            s_next.awRdy = 1'b0;
        end

        if (s_axi_wvalid && s_reg.wRdy) begin
            s_next.wData = s_axi_wdata;
            s_next.wStrb = s_axi_wstrb;
            s_next.wRdy = 1'b0;
        end
        doWr = !s_reg.awRdy && !s_reg.wRdy && !s_reg.bValid;

        mrg = merge(32'h0000_0000, s_reg.wData, s_reg.wStrb);

        if (doWr) begin
            s_next.bValid = 1'b1;
            s_next.bResp = `RXLS_RESP_OKAY;
            case (s_reg.awAddr & 8'hFC)
                `RXLS_OFS_MAXLEN: begin
                    upd = merge({17'h00000, s_reg.maxLen},
                                s_reg.wData, s_reg.wStrb);
                    s_next.maxLen = upd[14:0];
                end
                `RXLS_OFS_CLEAR: begin
                    clr = mrg[5:0];
                end
                `RXLS_OFS_ENABLE: begin
                    upd = merge({26'h0000000, s_reg.irqEn},
                                s_reg.wData, s_reg.wStrb);
                    s_next.irqEn = upd[5:0];
                end
                `RXLS_OFS_STATUS, `RXLS_OFS_SYNCED,
                `RXLS_OFS_DEMUXED: begin
                    s_next.bResp = `RXLS_RESP_OKAY;
                end
                default: begin
                    s_next.bResp = `RXLS_RESP_SLVERR;
                end
            endcase
        end

        if (s_reg.bValid && s_axi_bready) begin
            s_next.bValid = 1'b0;
            s_next.awRdy = 1'b1;
            s_next.wRdy = 1'b1;
        end

        // a new event beats a clear in the same cycle
        s_next.irqSts = (s_reg.irqSts & ~clr) | ev;
        s_next.irq = |(s_next.irqSts & s_reg.irqEn);

        // read data latched with the address, stands until taken
        if (s_axi_arvalid && s_reg.arRdy) begin
            s_next.arRdy = 1'b0;
            s_next.rValid = 1'b1;
            s_next.rResp = `RXLS_RESP_OKAY;
            case (s_axi_araddr & 8'hFC)
                `RXLS_OFS_MAXLEN:  s_next.rData = {17'h00000, s_reg.maxLen};
                `RXLS_OFS_STATUS:  s_next.rData = {26'h0000000, s_reg.irqSts};
                `RXLS_OFS_CLEAR:   s_next.rData = 32'h0000_0000;
                `RXLS_OFS_ENABLE:  s_next.rData = {26'h0000000, s_reg.irqEn};
                `RXLS_OFS_SYNCED:  s_next.rData = {12'h000, s_reg.synced};
                `RXLS_OFS_DEMUXED: s_next.rData = {12'h000, s_reg.demuxed};
                default: begin
                    s_next.rData = 32'h0000_0000;
                    s_next.rResp = `RXLS_RESP_SLVERR;
                end
            endcase
        end

        if (s_reg.rValid && s_axi_rready) begin
            s_next.rValid = 1'b0;
            s_next.arRdy = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg <= '{maxLen: `RXLS_MAXLEN_RST, awRdy: 1'b1, wRdy: 1'b1,
                       arRdy: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign statPcslNum = s_reg.pcslNum;
    assign statSynced = s_reg.synced;
    assign statDemuxed = s_reg.demuxed;
    assign statBadFcs = s_reg.badFcs;
    assign statStompedFcs = s_reg.stomped;
    assign statTruncated = s_reg.trunc;
    assign statIntLf = s_reg.intLf;
    assign statRxLf = rxLfLvl;
    assign statBipErr = bipErrLvl;
    assign irq = s_reg.irq;
    assign s_axi_awready = s_reg.awRdy;
    assign s_axi_wready = s_reg.wRdy;
    assign s_axi_bvalid = s_reg.bValid;
    assign s_axi_bresp = s_reg.bResp;
    assign s_axi_arready = s_reg.arRdy;
    assign s_axi_rvalid = s_reg.rValid;
    assign s_axi_rdata = s_reg.rData;
    assign s_axi_rresp = s_reg.rResp;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence longWord;
        rxEna && !rxEop && (rxSop || !s_reg.cutting)
        && ((rxSop ? 16'h0000 : s_reg.pktLen) + {9'h000, rxBytes}
            > {1'b0, s_reg.maxLen});
    endsequence

    sequence cutAndHold;
        statTruncated && s_reg.cutting ##1 !statTruncated;
    endsequence

    a_pcsl_gated: assert property (
        !laneSynced[0] |=> statPcslNum[0] == 5'h00) // RULE2
        else $error("lane number shown while unsynced");

    a_pcsl_follow: assert property (
        laneSynced[19] |=> statPcslNum[19] == $past(lanePcslIn[19])) // RULE1
        else $error("lane number does not follow input");

    a_demux_level: assert property (
        ##1 statDemuxed == $past(laneDemuxed)) // RULE3
        else $error("demux flags wrong");

    a_stomp_class: assert property (
        fcsValid[0] && fcsRx[0] == ~fcsCalc[0] && fcsValid[3:1] == 3'h0
        |=> statStompedFcs == 4'h1 && statBadFcs == 4'h0) // RULE5
        else $error("stomped FCS misclassified");

    a_bad_count: assert property (
        fcsValid[0] && fcsRx[0] != fcsCalc[0] && fcsRx[0] != ~fcsCalc[0]
        && fcsValid[3:1] == 3'h0
        |=> statBadFcs == 4'h1 && statStompedFcs == 4'h0) // RULE4
        else $error("bad FCS count wrong");

    a_idle_zero: assert property (
        fcsValid == 4'h0 |=> statBadFcs == 4'h0 && statStompedFcs == 4'h0) // RULE14
        else $error("counts not zero without events");

    a_bad_pulse: assert property (
        fcsValid == 4'hF && fcsRx[0] != fcsCalc[0]
        && fcsRx[0] != ~fcsCalc[0] |=> statBadFcs != 4'h0) // RULE7
        else $error("bad FCS pulse missing");

    a_trunc_once: assert property (
        longWord ##1 (rxEna && !rxSop) |-> cutAndHold) // RULE8 RULE9
        else $error("truncation pulse not single");

    a_trunc_cause: assert property (
        longWord |=> statTruncated) // RULE8
        else $error("truncation missing");

    a_int_lf: assert property (
        ##1 statIntLf == $past(txTestPattern || rxAlignBad || rxHiBer)) // RULE10
        else $error("internal fault level wrong");

    a_bip_pulse: assert property (
        bipValid[5] && bipRx[5] != bipCalc[5] |=> statBipErr[5]
        ##1 (statBipErr[5] == $past(bipValid[5] && bipRx[5] != bipCalc[5]))) // RULE12 RULE13
        else $error("parity error pulse wrong");

    a_rx_lf_hold: assert property (
        statRxLf && !colValid |=> statRxLf) // RULE11
        else $error("received fault dropped without columns");

    a_irq_level: assert property (
        ##1 irq == |($past(s_next.irqSts) & $past(s_reg.irqEn)))
        else $error("interrupt level wrong");

    a_wr_close: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not closed");

    a_rd_close: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read response not closed");
endmodule

// *** test/rxls_user_mon.sv ***
// user-side monitor tallying status pulses
`timescale 1ns/1ps
module rxls_user_mon (
    input  wire logic       clk_sys,        // system clock
    input  wire logic       rst_n,          // sync reset
    input  wire logic [3:0] statBadFcs,     // bad count
    input  wire logic [3:0] statStompedFcs, // stomped count
    input  wire logic       statTruncated,  // cut pulse
    output logic [15:0]     monBad,         // bad total
    output logic [15:0]     monSt,          // stomped total
    output logic [15:0]     monTr           // cut total
);
    // sampled every cycle: a stretched pulse would inflate totals
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            monBad <= 16'h0;
            monSt  <= 16'h0;
            monTr  <= 16'h0;
        end else begin
            monBad <= monBad + 16'(statBadFcs);
            monSt  <= monSt + 16'(statStompedFcs);
            monTr  <= monTr + 16'(statTruncated);
        end
    end
endmodule

// *** test/tb_rx_lane_and_frame_status.sv ***
// random and directed bench of the receive status block
`timescale 1ns/1ps
`include "rxls_defs.svh"
module tb_rx_lane_and_frame_status;
    logic clk_sys, rst_n, rxEna, rxSop, rxEop, txTestPattern, en;
    logic rxAlignBad, rxHiBer, colValid, colIsLf, eTr, cut, eInt;
    logic [19:0] laneSynced, laneDemuxed, bipValid, eSyn, eDmx, eBip;
    logic [19:0] statSynced, statDemuxed, statBipErr;
    logic [19:0][4:0] lanePcslIn, statPcslNum, ePcsl;
    logic [19:0][7:0] bipRx, bipCalc;
    logic [3:0] fcsValid, statBadFcs, statStompedFcs, eBad, eSt;
    logic [3:0][31:0] fcsRx, fcsCalc;
    logic [6:0] rxBytes;
    logic statTruncated, statIntLf, statRxLf, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, c, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [15:0] len, nl, monBad, monSt, monTr, totBad, totSt, totTr;
    int errors, checks_done, n;

    rxls_top rxls_top_inst (.*);
    rxls_user_mon rxls_user_mon_inst (.*);

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // st=1 counts inverted FCS, st=0 counts other wrong ones
    function automatic logic [3:0] fcnt(input bit st);
        fcnt = 4'h0;
        for (int k = 0; k < 4; k++)
            if (fcsValid[k] && ((fcsRx[k] == ~fcsCalc[k]) == st)
                && (st || fcsRx[k] != fcsCalc[k]))
                fcnt++;
    endfunction

    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [99:0] e, s);
        checks_done++;
        if (e !== s) begin
            $display("MISMATCH %s exp %h got %h", nm, e, s);
            errors++;
        end
    endtask

    task automatic tmo();
        n++;
        if (n > 60) begin
            errors++;
            report_and_stop();
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            tmo();
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge clk_sys);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            tmo();
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        {rst_n, rxEna, rxSop, rxEop, txTestPattern, rxAlignBad} = '0;
        {rxHiBer, colValid, colIsLf, laneSynced, laneDemuxed} = '0;
        {bipValid, lanePcslIn, bipRx, bipCalc, fcsValid, fcsRx} = '0;
        {fcsCalc, rxBytes, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, len, cut, totBad, totSt, totTr} = '0;
        {errors, checks_done} = '0;
        s_axi_wstrb = 4'hF;
        seed = 32'hA3D619F4;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        axr(`RXLS_OFS_MAXLEN);
        chk("maxlen rst", `RXLS_MAXLEN_RST, rd);
        axw(`RXLS_OFS_MAXLEN, 32'h64);
        for (int it = 0; it < 400; it++) begin
            @(posedge clk_sys);
            for (int i = 0; i < 20; i++)
                ePcsl[i] = laneSynced[i] ? lanePcslIn[i] : 5'h00;
            for (int i = 0; i < 20; i++)
                eBip[i] = bipValid[i] && bipRx[i] != bipCalc[i];
            {eSyn, eDmx, eBad, eSt} = {laneSynced, laneDemuxed, fcnt(0), fcnt(1)};
            eInt = txTestPattern | rxAlignBad | rxHiBer;
            eTr = 1'b0;
            if (rxEna) begin
                nl = (rxSop ? 16'h0 : len) + rxBytes;
                eTr = nl > 16'h64 && !(cut && !rxSop);
                cut = rxEop ? 1'b0 : (eTr || (cut && !rxSop));
                len = rxEop ? 16'h0 : nl;
            end
            {totBad, totSt, totTr} = {totBad + eBad, totSt + eSt, totTr + eTr};
            // last pass idles the event inputs so the totals settle
            en = it < 399;
            rd = xs();
            fcsValid <= en ? rd[3:0] : 4'h0;
            {rxEna, rxSop, rxEop} <= {en & rd[4], rd[5], rd[6] & rd[7]};
            {txTestPattern, rxAlignBad, rxHiBer} <= {&rd[9:8], &rd[11:10], &rd[13:12]};
            rxBytes <= 7'(xs() % 65);
            {laneSynced, laneDemuxed} <= {20'(xs()), 20'(xs())};
            bipValid <= en ? 20'(xs()) : 20'h0;
            for (int k = 0; k < 4; k++) begin
                c = xs();
                fcsCalc[k] <= c;
                fcsRx[k] <= c[1:0] == 0 ? c : c[1:0] == 1 ? ~c : c ^ 32'h8;
            end
            for (int i = 0; i < 20; i++) begin
                c = xs();
                lanePcslIn[i] <= c[20:16];
                bipCalc[i] <= c[7:0];
                bipRx[i] <= c[8] ? c[7:0] : c[15:8];
            end
            #1;
            chk("pcsl", ePcsl, statPcslNum);
            chk("synced", eSyn, statSynced);
            chk("demuxed", eDmx, statDemuxed);
            chk("bad", eBad, statBadFcs);
            chk("stomped", eSt, statStompedFcs);
            chk("trunc", eTr, statTruncated);
            chk("intlf", eInt, statIntLf);
            chk("bip", eBip, statBipErr);
        end
        laneSynced <= 20'hA5A5A;
        repeat (3) @(posedge clk_sys);
        chk("mon bad", totBad, monBad);
        chk("mon st", totSt, monSt);
        chk("mon tr", totTr, monTr);
        axr(`RXLS_OFS_SYNCED);
        chk("synced reg", 32'hA5A5A, rd);
        axw(`RXLS_OFS_ENABLE, 32'h1);
        chk("bresp", `RXLS_RESP_OKAY, rr);
        repeat (3) @(posedge clk_sys);
        chk("irq on", 1'b1, irq);
        axw(`RXLS_OFS_CLEAR, 32'h3F);
        repeat (3) @(posedge clk_sys);
        chk("irq off", 1'b0, irq);
        axr(`RXLS_OFS_CLEAR);
        chk("clear rd", 32'h0, rd);
        axr(8'h40);
        chk("unmapped", {`RXLS_RESP_SLVERR, 32'h0}, {rr, rd});
        colValid <= 1'b1;
        colIsLf <= 1'b1;
        repeat (4) @(posedge clk_sys);
        colIsLf <= 1'b0;
        n = 0;
        while (statRxLf !== 1'b1) begin
            @(posedge clk_sys);
            tmo();
        end
        repeat (100) @(posedge clk_sys);
        chk("rxlf held", 1'b1, statRxLf);
        repeat (40) @(posedge clk_sys);
        chk("rxlf gone", 1'b0, statRxLf);
        report_and_stop();
    end
endmodule
